/* src/cafb_alu.sv */
// ALU, condition-code update and branch target datapath of an 8-bit core.
// Assumes the sequencer presents one operation per start pulse, operands
// already fetched; results and flags are registered one edge later.
//
// How it works
// - Index add adds second accumulator unsigned into index; flags untouched.
// - Add with carry writes acc+mem+C; sets H,N,Z,V,C from result.
// - Plain 8-bit add updates the same flags, carry-in not used.
// - Double add adds 16-bit memory word into D; H kept.
// - AND stores acc&mem, N,Z from result, V cleared, H,C kept.
// - Flags AND replaces whole condition register with its AND against immediate.
// - Bit test updates N,Z, clears V, writes no accumulator.
// - Left shift inserts zero; C old bit7, V bit6^bit7, H undefined.
// - Right shift keeps bit7; C old bit0, V kept, N,Z follow.
// - Carry-clear branch taken only when C is 0; branches keep flags.
// - Carry-set branch taken only when C is 1.
// - Equal branch taken only when Z is set.
// - Signed greater-or-equal taken when N xor V is 0.
// - Signed greater-than taken when N equals V and Z clear.
// - Unsigned higher taken when C and Z are both 0.
// - Signed less-or-equal taken when N xor V is 1 or Z set.
// - Unsigned lower-or-same taken when C or Z is 1.
`timescale 1ns/1ns
`default_nettype none

module cafb_alu #(
  parameter int DATA_W = 8
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic start,
  input wire cafb_pkg::cafb_op_t op,
  input wire logic acc_sel_b,
  input wire logic shift_on_mem,
  input wire logic [7:0] mem_byte,
  input wire logic [15:0] mem_word,
  input wire cafb_pkg::cafb_cond_t branch_cond,
  input wire logic long_branch,
  input wire logic [15:0] branch_offset,
  input wire logic [15:0] next_pc_in,
  input wire logic load_enable,
  input wire logic [7:0] load_acc_a,
  input wire logic [7:0] load_acc_b,
  input wire logic [15:0] load_index,
  input wire logic [7:0] load_cc,
  output logic [7:0] first_accumulator,
  output logic [7:0] second_accumulator,
  output logic [15:0] first_index_register,
  output logic [7:0] cc,
  output logic [7:0] mem_result,
  output logic mem_write,
  output logic [15:0] program_counter,
  output logic pc_load,
  output logic branch_taken,
  output logic done
);

  // ==========================================================================
  // Elaboration check
  if (DATA_W != 8) begin : g_bad_width
    $error("cafb_alu supports only an 8-bit data path");
  end

  // ==========================================================================
  // Helpers
  function automatic logic [8:0] add9(input logic [7:0] a, input logic [7:0] b,
                                      input logic cin);
    add9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
  endfunction

  // Signed overflow from the two operand signs and the result sign
  function automatic logic sovf(input logic sa, input logic sb, input logic sr);
    sovf = (sa == sb) && (sr != sa);
  endfunction

  // Zero test shared by every 8-bit flag update
  function automatic logic is_zero8(input logic [7:0] r);
    is_zero8 = (r == 8'h00);
  endfunction

  // Negative and zero from an 8-bit result; every other flag passes through
  function automatic logic [7:0] with_nz8(input logic [7:0] f, input logic [7:0] r);
    with_nz8 = f;
    with_nz8[cafb_pkg::CAFB_CC_N] = r[cafb_pkg::CAFB_SIGN_BIT];
    with_nz8[cafb_pkg::CAFB_CC_Z] = is_zero8(r);
  endfunction

  // Short branch offsets carry their sign in bit 7
  function automatic logic [15:0] sext8(input logic [7:0] b);
    sext8 = {{8{b[7]}}, b};
  endfunction

  // ==========================================================================
  // Operand selection
  logic [7:0] acc;
  logic [7:0] shift_src;
  logic [15:0] dacc;

  assign acc = acc_sel_b ? second_accumulator : first_accumulator;
  assign shift_src = shift_on_mem ? mem_byte : acc;
  assign dacc = {first_accumulator, second_accumulator};

  // ==========================================================================
  // Arithmetic and logic
  logic [8:0] sum8;
  logic [4:0] low_nib;
  logic [16:0] sum16;
  logic [7:0] and8;
  logic [7:0] asl8;
  logic [7:0] asr8;
  logic carry_in;

  always_comb begin
    carry_in = (op == cafb_pkg::CAFB_OP_ADC) ? cc[cafb_pkg::CAFB_CC_C] : 1'b0;
  end

  assign sum8 = add9(acc, mem_byte, carry_in);
  // Carry out of bit 3 found by a nibble add
  assign low_nib = {1'b0, acc[3:0]} + {1'b0, mem_byte[3:0]} + {4'h0, carry_in};
  // Memory word already holds high byte from the lower address in [15:8]
  assign sum16 = {1'b0, dacc} + {1'b0, mem_word};
  assign and8 = acc & mem_byte;
  assign asl8 = {shift_src[6:0], 1'b0};
  assign asr8 = {shift_src[7], shift_src[7:1]};

  // ==========================================================================
  // Branch evaluation and target
  logic cond_true;
  logic [15:0] offset_ext;
  logic [15:0] target;

  cafb_branch_eval u_branch_eval (
    .cond(branch_cond),
    .cc(cc),
    .taken(cond_true)
  );

  assign offset_ext = long_branch ? branch_offset : sext8(branch_offset[7:0]);
  assign target = next_pc_in + offset_ext;

  // ==========================================================================
  // Operation classes
  logic op_go;
  logic op_shift;
  logic [7:0] shift_res;

  // Load wins over start, so a clashing start does nothing
  assign op_go = start && !load_enable;
  assign op_shift = (op == cafb_pkg::CAFB_OP_ASL) || (op == cafb_pkg::CAFB_OP_ASR);
  assign shift_res = (op == cafb_pkg::CAFB_OP_ASL) ? asl8 : asr8;

  // ==========================================================================
  // Next-state: accumulator result steering
  logic acc_writes;
  logic [7:0] acc_result;

  // One result byte for all 8-bit ops keeps the A/B steering in one place
  always_comb begin
    acc_writes = 1'b0;
    acc_result = acc;
    unique case (op)
      cafb_pkg::CAFB_OP_ADC, cafb_pkg::CAFB_OP_ADD8: begin
        acc_writes = 1'b1;
        acc_result = sum8[7:0];
      end
      cafb_pkg::CAFB_OP_AND: begin
        acc_writes = 1'b1;
        acc_result = and8;
      end
      cafb_pkg::CAFB_OP_ASL, cafb_pkg::CAFB_OP_ASR: begin
        acc_writes = !shift_on_mem;
        acc_result = shift_res;
      end
      // Bit test and the rest write no 8-bit result; the word add loads A and B below
      default: begin
        acc_writes = 1'b0;
        acc_result = acc;
      end
    endcase
  end

  // ==========================================================================
  // Next-state: registers and memory write-back
  logic [7:0] next_a;
  logic [7:0] next_b;
  logic [15:0] next_x;
  logic [7:0] next_mem;
  logic next_mem_write;

  always_comb begin
    next_a = first_accumulator;
    next_b = second_accumulator;
    next_x = first_index_register;
    next_mem = mem_result;
    next_mem_write = 1'b0;
    if (op == cafb_pkg::CAFB_OP_INDEX_ADD) begin
      next_x = first_index_register + {8'h00, second_accumulator};
    end
    if (op == cafb_pkg::CAFB_OP_ADD16) begin
      next_a = sum16[15:8];
      next_b = sum16[7:0];
    end else if (acc_writes && acc_sel_b) begin
      next_b = acc_result;
    end else if (acc_writes) begin
      next_a = acc_result;
    end
    // Memory shifts leave both accumulators alone
    if (op_shift && shift_on_mem) begin
      next_mem = shift_res;
      next_mem_write = 1'b1;
    end
  end

  // ==========================================================================
  // Next-state: condition codes
  logic [7:0] next_cc;

  always_comb begin
    next_cc = cc;
    unique case (op)
      cafb_pkg::CAFB_OP_ADC, cafb_pkg::CAFB_OP_ADD8: begin
        next_cc = with_nz8(cc, sum8[7:0]);
        next_cc[cafb_pkg::CAFB_CC_H] = low_nib[cafb_pkg::CAFB_HALF_BIT];
        next_cc[cafb_pkg::CAFB_CC_V] = sovf(acc[7], mem_byte[7], sum8[7]);
        next_cc[cafb_pkg::CAFB_CC_C] = sum8[8];
      end
      cafb_pkg::CAFB_OP_ADD16: begin
        // Half-carry has no meaning for a word add and is kept
        next_cc[cafb_pkg::CAFB_CC_N] = sum16[15];
        next_cc[cafb_pkg::CAFB_CC_Z] = (sum16[15:0] == 16'h0000);
        next_cc[cafb_pkg::CAFB_CC_V] = sovf(dacc[15], mem_word[15], sum16[15]);
        next_cc[cafb_pkg::CAFB_CC_C] = sum16[16];
      end
      cafb_pkg::CAFB_OP_AND, cafb_pkg::CAFB_OP_BIT: begin
        next_cc = with_nz8(cc, and8);
        next_cc[cafb_pkg::CAFB_CC_V] = 1'b0;
      end
      cafb_pkg::CAFB_OP_FLAGS_AND: begin
        next_cc = cc & mem_byte;
      end
      // Half-carry is undefined after shifts; it is simply held
      cafb_pkg::CAFB_OP_ASL: begin
        next_cc = with_nz8(cc, shift_res);
        next_cc[cafb_pkg::CAFB_CC_C] = shift_src[cafb_pkg::CAFB_SIGN_BIT];
        next_cc[cafb_pkg::CAFB_CC_V] = shift_src[cafb_pkg::CAFB_PREV_BIT]
                                     ^ shift_src[cafb_pkg::CAFB_SIGN_BIT];
      end
      cafb_pkg::CAFB_OP_ASR: begin
        next_cc = with_nz8(cc, shift_res);
        next_cc[cafb_pkg::CAFB_CC_C] = shift_src[0];
      end
      // Branches and no-op leave every flag as it is
      default: begin
        next_cc = cc;
      end
    endcase
  end

  // ==========================================================================
  // Registers: accumulators and index
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      first_accumulator <= cafb_pkg::CAFB_BYTE_RESET;
      second_accumulator <= cafb_pkg::CAFB_BYTE_RESET;
      first_index_register <= cafb_pkg::CAFB_WORD_RESET;
    end else if (load_enable) begin
      first_accumulator <= load_acc_a;
      second_accumulator <= load_acc_b;
      first_index_register <= load_index;
    end else if (start) begin
      first_accumulator <= next_a;
      second_accumulator <= next_b;
      first_index_register <= next_x;
    end
  end

  // ==========================================================================
  // Registers: condition codes
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cc <= cafb_pkg::CAFB_CC_RESET;
    end else if (load_enable) begin
      cc <= load_cc;
    end else if (start) begin
      cc <= next_cc;
    end
  end

  // ==========================================================================
  // Registers: memory write-back
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mem_write <= 1'b0;
    end else begin
      mem_write <= op_go && next_mem_write;
    end
  end

  // Result byte holds until the next memory shift replaces it
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mem_result <= cafb_pkg::CAFB_BYTE_RESET;
    end else if (op_go) begin
      mem_result <= next_mem;
    end
  end

  // ==========================================================================
  // Registers: program counter
  logic is_branch;

  assign is_branch = op_go && (op == cafb_pkg::CAFB_OP_BRANCH);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      program_counter <= cafb_pkg::CAFB_WORD_RESET;
    end else if (is_branch) begin
      // Not taken still reports the sequential address
      program_counter <= cond_true ? target : next_pc_in;
    end
  end

  // ==========================================================================
  // Registers: branch report
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pc_load <= 1'b0;
      branch_taken <= 1'b0;
    end else begin
      pc_load <= is_branch;
      if (is_branch) begin
        branch_taken <= cond_true;
      end
    end
  end

  // ==========================================================================
  // Completion
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      done <= 1'b0;
    end else begin
      done <= op_go;
    end
  end

endmodule

`default_nettype wire

/* src/cafb_branch_eval.sv */
// Branch condition evaluator: pure combinational test of the flags.
// Assumes the flags given are the committed condition-code register.
`timescale 1ns/1ns
`default_nettype none

module cafb_branch_eval (
  input wire cafb_pkg::cafb_cond_t cond,
  input wire logic [7:0] cc,
  output logic taken
);

  logic c;
  logic v;
  logic z;
  logic n;

  assign c = cc[cafb_pkg::CAFB_CC_C];
  assign v = cc[cafb_pkg::CAFB_CC_V];
  assign z = cc[cafb_pkg::CAFB_CC_Z];
  assign n = cc[cafb_pkg::CAFB_CC_N];

  always_comb begin
    unique case (cond)
      cafb_pkg::CAFB_BR_CARRY_CLEAR: taken = !c;
      cafb_pkg::CAFB_BR_CARRY_SET: taken = c;
      cafb_pkg::CAFB_BR_EQUAL: taken = z;
      cafb_pkg::CAFB_BR_SIGNED_GE: taken = !(n ^ v);
      cafb_pkg::CAFB_BR_SIGNED_GT: taken = !(n ^ v) && !z;
      cafb_pkg::CAFB_BR_UNS_HIGHER: taken = !(c | z);
      cafb_pkg::CAFB_BR_SIGNED_LE: taken = (n ^ v) || z;
      cafb_pkg::CAFB_BR_UNS_LE: taken = c | z;
      cafb_pkg::CAFB_BR_ALWAYS: taken = 1'b1;
      default: taken = 1'b0;
    endcase
  end

endmodule

`default_nettype wire

/* src/cafb_pkg.sv */
// Package for the ALU, flag and branch-condition datapath.
// Assumes a single 125 MHz core clock; no bus, all controls are plain ports.
package cafb_pkg;

  // ==========================================================================
  // Operations
  typedef enum logic [3:0] {
    CAFB_OP_NONE      = 4'h0,
    CAFB_OP_INDEX_ADD = 4'h1,
    CAFB_OP_ADC       = 4'h2,
    CAFB_OP_ADD8      = 4'h3,
    CAFB_OP_ADD16     = 4'h4,
    CAFB_OP_AND       = 4'h5,
    CAFB_OP_FLAGS_AND = 4'h6,
    CAFB_OP_BIT       = 4'h7,
    CAFB_OP_ASL       = 4'h8,
    CAFB_OP_ASR       = 4'h9,
    CAFB_OP_BRANCH    = 4'ha
  } cafb_op_t;

  // ==========================================================================
  // Branch conditions
  typedef enum logic [3:0] {
    CAFB_BR_CARRY_CLEAR = 4'h0,
    CAFB_BR_CARRY_SET   = 4'h1,
    CAFB_BR_EQUAL       = 4'h2,
    CAFB_BR_SIGNED_GE   = 4'h3,
    CAFB_BR_SIGNED_GT   = 4'h4,
    CAFB_BR_UNS_HIGHER  = 4'h5,
    CAFB_BR_SIGNED_LE   = 4'h6,
    CAFB_BR_UNS_LE      = 4'h7,
    CAFB_BR_ALWAYS      = 4'h8,
    CAFB_BR_NEVER       = 4'h9
  } cafb_cond_t;

  // ==========================================================================
  // Condition-code bit positions
  localparam int CAFB_CC_C = 0;
  localparam int CAFB_CC_V = 1;
  localparam int CAFB_CC_Z = 2;
  localparam int CAFB_CC_N = 3;
  localparam int CAFB_CC_I = 4;
  localparam int CAFB_CC_H = 5;
  localparam int CAFB_CC_F = 6;
  localparam int CAFB_CC_E = 7;

  localparam int CAFB_HALF_BIT = 4;
  localparam int CAFB_SIGN_BIT = 7;
  localparam int CAFB_PREV_BIT = 6;

  // Reset values
  localparam logic [7:0] CAFB_CC_RESET = 8'h50;
  localparam logic [15:0] CAFB_WORD_RESET = 16'h0000;
  localparam logic [7:0] CAFB_BYTE_RESET = 8'h00;

endpackage

/* testbench/cafb_alu_asserts.sv */
// Checker for the ALU, flag and branch datapath.
// Assumes it is bound to cafb_alu and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module cafb_alu_asserts (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic start,
  input wire cafb_pkg::cafb_op_t op,
  input wire logic load_enable,
  input wire logic [7:0] mem_byte,
  input wire cafb_pkg::cafb_cond_t branch_cond,
  input wire logic [7:0] first_accumulator,
  input wire logic [7:0] second_accumulator,
  input wire logic [15:0] first_index_register,
  input wire logic [7:0] cc,
  input wire logic pc_load,
  input wire logic branch_taken,
  input wire logic done
);
  // ==========================================================================
  // Issue sequences
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence s_go(cafb_pkg::cafb_op_t o);
    start && !load_enable && op == o;
  endsequence
  sequence s_br(cafb_pkg::cafb_cond_t c);
    start && !load_enable && op == cafb_pkg::CAFB_OP_BRANCH && branch_cond == c;
  endsequence

  // ==========================================================================
  // Properties
  a_index_add_sum: assert property (s_go(cafb_pkg::CAFB_OP_INDEX_ADD) |=>
    first_index_register == $past(first_index_register) + {8'h00, $past(second_accumulator)}
    && cc == $past(cc)) else $error("index add wrong");
  a_flags_and_mask: assert property (s_go(cafb_pkg::CAFB_OP_FLAGS_AND) |=>
    cc == ($past(cc) & $past(mem_byte))) else $error("flags and wrong");
  a_and_clears_ov: assert property (s_go(cafb_pkg::CAFB_OP_AND) |=>
    !cc[1] && cc[0] == $past(cc[0]) && cc[5] == $past(cc[5])) else $error("and flags wrong");
  a_bit_keeps_acc: assert property (s_go(cafb_pkg::CAFB_OP_BIT) |=>
    $stable(first_accumulator) && $stable(second_accumulator) && !cc[1])
    else $error("bit test changed state");
  a_branch_keeps_cc: assert property (s_go(cafb_pkg::CAFB_OP_BRANCH) |=>
    $stable(cc) && pc_load) else $error("branch changed flags");
  a_carry_clear_br: assert property (s_br(cafb_pkg::CAFB_BR_CARRY_CLEAR) |=>
    branch_taken == !$past(cc[0])) else $error("carry clear decision wrong");
  a_equal_br: assert property (s_br(cafb_pkg::CAFB_BR_EQUAL) |=>
    branch_taken == $past(cc[2])) else $error("equal decision wrong");
  a_signed_gt_br: assert property (s_br(cafb_pkg::CAFB_BR_SIGNED_GT) |=>
    branch_taken == (!$past(cc[2]) && $past(cc[3]) == $past(cc[1])))
    else $error("signed greater decision wrong");
  a_uns_le_br: assert property (s_br(cafb_pkg::CAFB_BR_UNS_LE) |=>
    branch_taken == ($past(cc[0]) | $past(cc[2]))) else $error("lower same decision wrong");
  a_load_no_done: assert property (load_enable |=> !done && !pc_load)
    else $error("done after load");
  a_done_one_cycle: assert property (start && !load_enable ##1 !start |-> done ##1 !done)
    else $error("done pulse wrong");
endmodule

bind cafb_alu cafb_alu_asserts u_chk (.clock(clock), .reset_n(reset_n), .start(start),
  .op(op), .load_enable(load_enable), .mem_byte(mem_byte), .branch_cond(branch_cond),
  .first_accumulator(first_accumulator), .second_accumulator(second_accumulator),
  .first_index_register(first_index_register), .cc(cc), .pc_load(pc_load),
  .branch_taken(branch_taken), .done(done));
`default_nettype wire

/* testbench/cafb_alu_tb.sv */
// Self-checking bench for the ALU, flag and branch datapath.
// Assumes the sequencer model drives every control input of the block.
`timescale 1ns/1ns
`default_nettype none
module cafb_alu_tb;
  logic clock = 1'h0;
  logic reset_n = 1'h0;
  int n_errors = 0;
  int checks_done = 0;
  logic start, acc_sel_b, shift_on_mem, long_branch, load_enable;
  cafb_pkg::cafb_op_t op;
  cafb_pkg::cafb_cond_t branch_cond;
  logic [7:0] mem_byte, load_acc_a, load_acc_b, load_cc;
  logic [15:0] mem_word, branch_offset, next_pc_in, load_index;
  logic [7:0] first_accumulator, second_accumulator, cc, mem_result;
  logic [15:0] first_index_register, program_counter;
  logic mem_write, pc_load, branch_taken, done;

  always #4 clock = ~clock;

  cafb_seq_model u_seq (.clock, .start, .op, .acc_sel_b, .shift_on_mem, .mem_byte,
    .mem_word, .branch_cond, .long_branch, .branch_offset, .next_pc_in, .load_enable,
    .load_acc_a, .load_acc_b, .load_index, .load_cc);
  cafb_alu u_dut (.clock, .reset_n, .start, .op, .acc_sel_b, .shift_on_mem, .mem_byte,
    .mem_word, .branch_cond, .long_branch, .branch_offset, .next_pc_in, .load_enable,
    .load_acc_a, .load_acc_b, .load_index, .load_cc, .first_accumulator,
    .second_accumulator, .first_index_register, .cc, .mem_result, .mem_write,
    .program_counter, .pc_load, .branch_taken, .done);

  // ==========================================================================
  // Helpers
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic exp_taken(input cafb_pkg::cafb_cond_t c, input logic [3:0] f);
    logic n, z, v, cy;
    {n, z, v, cy} = f;
    case (c)
      cafb_pkg::CAFB_BR_CARRY_CLEAR: return !cy;
      cafb_pkg::CAFB_BR_CARRY_SET: return cy;
      cafb_pkg::CAFB_BR_EQUAL: return z;
      cafb_pkg::CAFB_BR_SIGNED_GE: return !(n ^ v);
      cafb_pkg::CAFB_BR_SIGNED_GT: return !(n ^ v) && !z;
      cafb_pkg::CAFB_BR_UNS_HIGHER: return !(cy | z);
      cafb_pkg::CAFB_BR_SIGNED_LE: return (n ^ v) | z;
      cafb_pkg::CAFB_BR_UNS_LE: return cy | z;
      cafb_pkg::CAFB_BR_ALWAYS: return 1'h1;
      default: return 1'h0;
    endcase
  endfunction
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    chk("acc", {first_accumulator, second_accumulator}, 16'h0000);
    chk("cc", {8'h00, cc}, 16'h0050);
    chk("pc", program_counter, 16'h0000);
    $display("t_reset finished");
  endtask
  task automatic t_arith();
    u_seq.load(8'h08, 8'hff, 16'h1234, 8'h01);
    u_seq.issue(cafb_pkg::CAFB_OP_INDEX_ADD, 1'h0, 1'h0, 8'h00, 16'h0000);
    chk("index", first_index_register, 16'h1333);
    chk("cc", {8'h00, cc}, 16'h0001);
    chk("done", {15'h0, done}, 16'h0001);
    u_seq.issue(cafb_pkg::CAFB_OP_ADD8, 1'h0, 1'h0, 8'h78, 16'h0000);
    chk("add", {first_accumulator, cc}, 16'h802a);
    u_seq.load(8'h11, 8'hff, 16'h0000, 8'h01);
    u_seq.issue(cafb_pkg::CAFB_OP_ADC, 1'h1, 1'h0, 8'h00, 16'h0000);
    chk("adc", {second_accumulator, cc}, 16'h0025);
    chk("acc", {8'h00, first_accumulator}, 16'h0011);
    u_seq.load(8'h80, 8'h00, 16'h0000, 8'h20);
    u_seq.issue(cafb_pkg::CAFB_OP_ADD16, 1'h0, 1'h0, 8'h00, 16'h8000);
    chk("dadd", {first_accumulator, second_accumulator}, 16'h0000);
    chk("cc", {8'h00, cc}, 16'h0027);
    $display("t_arith finished");
  endtask
  task automatic t_logic();
    u_seq.load(8'hf0, 8'h0f, 16'h0000, 8'h23);
    u_seq.issue(cafb_pkg::CAFB_OP_AND, 1'h0, 1'h0, 8'h8f, 16'h0000);
    chk("and", {first_accumulator, cc}, 16'h8029);
    u_seq.issue(cafb_pkg::CAFB_OP_BIT, 1'h1, 1'h0, 8'hf0, 16'h0000);
    chk("bit", {second_accumulator, cc}, 16'h0f25);
    u_seq.load(8'h41, 8'h00, 16'h0000, 8'hff);
    u_seq.issue(cafb_pkg::CAFB_OP_FLAGS_AND, 1'h0, 1'h0, 8'ha5, 16'h0000);
    chk("ccand", {8'h00, cc}, 16'h00a5);
    u_seq.load(8'h41, 8'h00, 16'h0000, 8'h01);
    // Half-carry is undefined after shifts, so it is masked out
    u_seq.issue(cafb_pkg::CAFB_OP_ASL, 1'h0, 1'h0, 8'h00, 16'h0000);
    chk("asl", {first_accumulator, cc & 8'hdf}, 16'h820a);
    chk("mem_write", {15'h0, mem_write}, 16'h0000);
    u_seq.issue(cafb_pkg::CAFB_OP_ASR, 1'h0, 1'h1, 8'h81, 16'h0000);
    chk("asr", {mem_result, cc & 8'hdf}, 16'hc00b);
    chk("mem_write", {first_accumulator, 7'h0, mem_write}, 16'h8201);
    $display("t_logic finished");
  endtask
  task automatic t_branch();
    cafb_pkg::cafb_cond_t c;
    logic t;
    for (int i = 0; i < 10; i++) begin
      for (int k = 0; k < 16; k++) begin
        c = cafb_pkg::cafb_cond_t'(i[3:0]);
        t = exp_taken(c, k[3:0]);
        u_seq.load(8'h00, 8'h00, 16'h0000, {4'h5, k[3:0]});
        u_seq.branch(c, i[0], 16'h12fe, 16'h4000);
        chk("taken", {15'h0, branch_taken}, {15'h0, t});
        chk("pc", program_counter, t ? (i[0] ? 16'h52fe : 16'h3ffe) : 16'h4000);
        chk("pc_load", {15'h0, pc_load}, 16'h0001);
        chk("cc", {8'h00, cc}, {8'h05, k[3:0]});
      end
    end
    $display("t_branch finished");
  endtask
  task automatic t_mid_reset();
    u_seq.load(8'h5a, 8'ha5, 16'h5aa5, 8'hff);
    reset_n = 1'h0;
    #1;
    chk("acc", {first_accumulator, second_accumulator}, 16'h0000);
    chk("index", first_index_register, 16'h0000);
    chk("cc", {8'h00, cc}, 16'h0050);
    repeat (2) @(posedge clock);
    #1;
    reset_n = 1'h1;
    u_seq.issue(cafb_pkg::CAFB_OP_ADD8, 1'h0, 1'h0, 8'h01, 16'h0000);
    chk("add", {first_accumulator, cc}, 16'h0150);
    $display("t_mid_reset finished");
  endtask

  initial begin
    #100000;
    n_errors++;
    finish_test();
  end
  initial begin
    repeat (10) @(posedge clock);
    #1;
    reset_n = 1'h1;
    t_reset();
    t_arith();
    t_logic();
    t_branch();
    t_mid_reset();
    finish_test();
  end
endmodule
`default_nettype wire

/* testbench/cafb_seq_model.sv */
// Sequencer model: issues one operation or one preload per task call.
// Assumes the block shares its clock; drives 1 ns after each rising edge.
`timescale 1ns/1ns
`default_nettype none
module cafb_seq_model (
  input wire logic clock,
  output logic start,
  output cafb_pkg::cafb_op_t op,
  output logic acc_sel_b,
  output logic shift_on_mem,
  output logic [7:0] mem_byte,
  output logic [15:0] mem_word,
  output cafb_pkg::cafb_cond_t branch_cond,
  output logic long_branch,
  output logic [15:0] branch_offset,
  output logic [15:0] next_pc_in,
  output logic load_enable,
  output logic [7:0] load_acc_a,
  output logic [7:0] load_acc_b,
  output logic [15:0] load_index,
  output logic [7:0] load_cc
);
  // ==========================================================================
  // Drivers
  initial begin
    {start, load_enable, acc_sel_b, shift_on_mem, long_branch} = 5'h0;
    op = cafb_pkg::CAFB_OP_NONE;
    branch_cond = cafb_pkg::CAFB_BR_NEVER;
    {mem_byte, mem_word, branch_offset, next_pc_in} = 56'h0;
    {load_acc_a, load_acc_b, load_index, load_cc} = 40'h0;
  end
  task automatic issue(input cafb_pkg::cafb_op_t o, input logic sel, input logic shm,
                       input logic [7:0] m8, input logic [15:0] m16);
    @(posedge clock);
    #1;
    op = o;
    acc_sel_b = sel;
    shift_on_mem = shm;
    mem_byte = m8;
    mem_word = m16;
    start = 1'h1;
    @(posedge clock);
    #1;
    start = 1'h0;
    // Inverted leftovers, so a late sample in the block shows up
    mem_byte = ~m8;
    mem_word = ~m16;
  endtask
  task automatic branch(input cafb_pkg::cafb_cond_t c, input logic lng,
                        input logic [15:0] off, input logic [15:0] npc);
    branch_cond = c;
    long_branch = lng;
    branch_offset = off;
    next_pc_in = npc;
    issue(cafb_pkg::CAFB_OP_BRANCH, 1'h0, 1'h0, 8'h00, 16'h0000);
    branch_offset = ~off;
    next_pc_in = ~npc;
  endtask
  task automatic load(input logic [7:0] a, input logic [7:0] b, input logic [15:0] x,
                      input logic [7:0] f);
    @(posedge clock);
    #1;
    load_acc_a = a;
    load_acc_b = b;
    load_index = x;
    load_cc = f;
    load_enable = 1'h1;
    @(posedge clock);
    #1;
    load_enable = 1'h0;
  endtask
endmodule
`default_nettype wire
